// *** hw/card_ocr_pkg.sv ***
/*
 * Shared constants for the card-side operating-conditions block: word layout,
 * command frame layout, command codes, status bits and timeout figures.
 * Assumes a 250 MHz system clock; all timing counts are derived from it.
 */
package card_ocr_pkg;

    // Operating-conditions word layout
    localparam int          OCR_W          = 32;
    localparam int          OCR_VDD_LO_BIT = 15;
    localparam int          OCR_VDD_HI_BIT = 23;
    localparam int          OCR_LVS_BIT    = 24;
    localparam int          OCR_CCS_BIT    = 30;
    localparam int          OCR_BUSY_BIT   = 31;
    localparam logic [31:0] OCR_VDD_MASK   = 32'h00ff8000;
    localparam logic [31:0] OCR_RSVD_VALUE = 32'h00000000;

    // Command and response frame layout
    localparam int         FRAME_BITS   = 48;
    localparam logic [5:0] CRC_FIRST    = 6'h28;
    localparam logic [5:0] LAST_BIT     = 6'h2f;
    localparam logic [5:0] FRAME_END    = 6'h30;
    localparam logic [5:0] GAP_EDGES    = 6'h02;
    localparam logic [6:0] CRC7_POLY    = 7'h09;
    localparam logic [6:0] CRC_ONES     = 7'h7f;
    localparam logic [5:0] R3_INDEX     = 6'h3f;

    // Command codes
    localparam logic [5:0] CMD_GO_IDLE  = 6'h00;
    localparam logic [5:0] CMD_OP_COND  = 6'h29;
    localparam logic [5:0] CMD_LOCK     = 6'h2a;
    localparam logic [5:0] CMD_APP      = 6'h37;

    // Card status bits returned in short responses
    localparam int ST_LOCKED_BIT    = 25;
    localparam int ST_LOCK_FAIL_BIT = 24;
    localparam int ST_APP_CMD_BIT   = 5;

    // Lock command argument fields
    localparam int LK_SET_PWD_BIT = 0;
    localparam int LK_CLR_PWD_BIT = 1;
    localparam int LK_LOCK_BIT    = 2;
    localparam int LK_PWD_LSB     = 8;
    localparam int PWD_W          = 24;

    // Timeouts, in milliseconds, and their cycle counts
    localparam int TIMER_W          = 27;
    localparam int SYS_CLK_KHZ      = 250000;
    localparam int READ_TIMEOUT_MS  = 100;
    localparam int WRITE_STD_MS     = 250;
    localparam int WRITE_EXT_MS     = 500;
    localparam int READ_TIMEOUT_CYC = READ_TIMEOUT_MS * SYS_CLK_KHZ;
    localparam int WRITE_STD_CYC    = WRITE_STD_MS * SYS_CLK_KHZ;
    localparam int WRITE_EXT_CYC    = WRITE_EXT_MS * SYS_CLK_KHZ;

    // Command engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_GAP  = 2'b10,
        ST_SEND = 2'b11
    } link_state_t;

endpackage

// *** hw/crc7_serial.sv ***
/*
 * Serial CRC7 over a bit stream, one bit per enabled clock.
 * Assumes the caller clears it before each frame and feeds bits msb first.
 */
`timescale 1ns/10ps
module crc7_serial (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Stream
    input  wire logic       clear,
    input  wire logic       en,
    input  wire logic       din,
    // Result
    output logic      [6:0] crc
);

    logic feedback;

    assign feedback = din ^ crc[6];

    // Clear takes priority so a new frame never inherits old remainder
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            crc <= 7'h00;
        end else if (clear) begin
            crc <= 7'h00;
        end else if (en) begin
            crc <= {crc[5:0], 1'b0} ^ (feedback ? card_ocr_pkg::CRC7_POLY : 7'h00);
        end
    end

endmodule

// *** hw/card_operating_conditions.sv ***
/*
 * Card-side command engine that serves the operating-conditions word over the
 * serial command line, keeps the lock state, and polices read/write timeouts.
 * Assumes the bus clock and command line arrive asynchronously on pins, and
 * that the flash back end sits on clk_sys and signals start/done as pulses.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - Operating-conditions word is 32 bits; bits 15 to 23 always read one.
// - Bits 0 to 14 read zero, bit 7 included.
// - Bit 31 stays low until power-up finishes, then reads one.
// - Bit 30 gives capacity class, driven only while bit 31 is set.
// - Bit 24 and bits 24 to 29 read zero.
// - Internal registers are reachable only through their own bus commands.
// - A block read must finish within 100 ms or be abandoned with error.
// - A block write finishes within 250 ms, 500 ms extended, else error.
// - Bus clock runs 0 to 25 MHz default, 0 to 50 MHz high speed.
// - Card supports password locking and unlocking through command 42.
module card_operating_conditions #(
    parameter int READ_TIMEOUT_CYC = card_ocr_pkg::READ_TIMEOUT_CYC,
    parameter int WRITE_STD_CYC    = card_ocr_pkg::WRITE_STD_CYC,
    parameter int WRITE_EXT_CYC    = card_ocr_pkg::WRITE_EXT_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Card bus pins
    input  wire logic sd_clk,
    input  wire logic cmd_in,
    output logic      cmd_out_q,
    output logic      cmd_oe_n_q,
    // Back-end status
    input  wire logic power_up_done,
    input  wire logic high_capacity,
    input  wire logic ext_capacity,
    // Back-end transfer tracking
    input  wire logic read_start,
    input  wire logic read_done,
    input  wire logic write_start,
    input  wire logic write_done,
    // Status outputs
    output logic      read_abort_q,
    output logic      write_abort_q,
    output logic      card_locked_q,
    output logic      power_up_status_q
);

    // Pin synchronisers and edge tracking
    logic sd_clk_m_q, sd_clk_s_q, sd_clk_p_q;
    logic cmd_m_q, cmd_s_q;
    logic bus_rise;

    // Command engine
    card_ocr_pkg::link_state_t state_q;
    logic [5:0]                bit_cnt_q;
    logic [47:0]               rx_sh_q;
    logic [47:0]               tx_sh_q;
    logic                      use_crc_q;
    logic [6:0]                rx_crc;
    logic [6:0]                tx_crc;

    // Card state
    logic                             app_q;
    logic                             lock_fail_q;
    logic                             has_pwd_q;
    logic [card_ocr_pkg::PWD_W-1:0]   pwd_q;

    // Timers
    logic                               rd_active_q, wr_active_q;
    logic [card_ocr_pkg::TIMER_W-1:0]   rd_cnt_q, wr_cnt_q;
    logic [card_ocr_pkg::TIMER_W-1:0]   wr_limit;

    // Decoded frame
    logic [47:0] frame;
    logic        frame_end;
    logic        frame_ok;
    logic [5:0]  cmd_idx;
    logic [31:0] cmd_arg;
    logic        is_idle_cmd, is_app_cmd, is_op_cond, is_lock_cmd;
    logic        pwd_match;

    // Builds the word; capacity only once power-up is done
    function automatic logic [31:0] build_ocr(input logic busy, input logic capacity_class_flag);
        logic [31:0] w;
        w = card_ocr_pkg::OCR_RSVD_VALUE;
        w = w | card_ocr_pkg::OCR_VDD_MASK;
        w[card_ocr_pkg::OCR_LVS_BIT] = 1'b0;
        w[card_ocr_pkg::OCR_CCS_BIT] = busy & capacity_class_flag;
        w[card_ocr_pkg::OCR_BUSY_BIT] = busy;
        return w;
    endfunction

    // Two flops on each pin before anything looks at it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sd_clk_m_q <= 1'b0;
            sd_clk_s_q <= 1'b0;
            sd_clk_p_q <= 1'b0;
            cmd_m_q    <= 1'b1;
            cmd_s_q    <= 1'b1;
        end else begin
            sd_clk_m_q <= sd_clk;
            sd_clk_s_q <= sd_clk_m_q;
            sd_clk_p_q <= sd_clk_s_q;
            cmd_m_q    <= cmd_in;
            cmd_s_q    <= cmd_m_q;
        end
    end

    // Bus clock at 50 MHz max gives ample sys samples per half period
    assign bus_rise = sd_clk_s_q & ~sd_clk_p_q;

    // Frame fields as seen on the last received bit
    assign frame       = {rx_sh_q[46:0], cmd_s_q};
    assign frame_end   = bus_rise && (state_q == card_ocr_pkg::ST_RECV) && (bit_cnt_q == card_ocr_pkg::LAST_BIT);
    assign frame_ok    = frame_end && frame[46] && frame[0] && (frame[7:1] == rx_crc);
    assign cmd_idx     = frame[45:40];
    assign cmd_arg     = frame[39:8];
    assign is_idle_cmd = frame_ok && (cmd_idx == card_ocr_pkg::CMD_GO_IDLE);
    assign is_app_cmd  = frame_ok && (cmd_idx == card_ocr_pkg::CMD_APP);
    assign is_op_cond  = frame_ok && app_q && (cmd_idx == card_ocr_pkg::CMD_OP_COND);
    assign is_lock_cmd = frame_ok && !app_q && (cmd_idx == card_ocr_pkg::CMD_LOCK);
    assign pwd_match   = has_pwd_q && (cmd_arg[card_ocr_pkg::LK_PWD_LSB +: card_ocr_pkg::PWD_W] == pwd_q);

    // Checksums for the incoming and outgoing frames
    crc7_serial u_rx_crc (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clear   (state_q == card_ocr_pkg::ST_IDLE),
        .en      (bus_rise && (state_q == card_ocr_pkg::ST_RECV) && (bit_cnt_q < card_ocr_pkg::CRC_FIRST)),
        .din     (cmd_s_q),
        .crc     (rx_crc)
    );

    crc7_serial u_tx_crc (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clear   (state_q != card_ocr_pkg::ST_SEND),
        .en      (bus_rise && (state_q == card_ocr_pkg::ST_SEND) && (bit_cnt_q < card_ocr_pkg::CRC_FIRST)),
        .din     (tx_sh_q[47]),
        .crc     (tx_crc)
    );

    // Frame engine; any valid frame other than the app command clears the prefix, only the app and lock commands set card state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= card_ocr_pkg::ST_IDLE;
            bit_cnt_q <= 6'h00;
            rx_sh_q   <= 48'h000000000000;
        end else if (bus_rise) begin
            case (state_q)
                card_ocr_pkg::ST_IDLE: begin
                    bit_cnt_q <= 6'h01;
                    rx_sh_q   <= 48'h000000000000;
                    if (!cmd_s_q) begin
                        state_q <= card_ocr_pkg::ST_RECV;
                    end
                end
                card_ocr_pkg::ST_RECV: begin
                    rx_sh_q   <= frame;
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                    if (frame_end) begin
                        bit_cnt_q <= 6'h00;
                        // Anything else stays unanswered: no side path in
                        state_q <= (is_app_cmd || is_op_cond || is_lock_cmd) ?
                                   card_ocr_pkg::ST_GAP : card_ocr_pkg::ST_IDLE;
                    end
                end
                card_ocr_pkg::ST_GAP: begin
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                    if (bit_cnt_q == card_ocr_pkg::GAP_EDGES - 6'h01) begin
                        bit_cnt_q <= 6'h00;
                        state_q   <= card_ocr_pkg::ST_SEND;
                    end
                end
                card_ocr_pkg::ST_SEND: begin
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                    if (bit_cnt_q == card_ocr_pkg::FRAME_END) begin
                        bit_cnt_q <= 6'h00;
                        state_q   <= card_ocr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= card_ocr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Response shift register and line driver
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sh_q    <= 48'h000000000000;
            use_crc_q  <= 1'b0;
            cmd_out_q  <= 1'b1;
            cmd_oe_n_q <= 1'b1;
        end else if (bus_rise) begin
            if (is_op_cond) begin
                // Long-form reply carries all ones in the checksum field
                tx_sh_q   <= {2'b00, card_ocr_pkg::R3_INDEX, build_ocr(power_up_status_q, high_capacity),
                              card_ocr_pkg::CRC_ONES, 1'b1};
                use_crc_q <= 1'b0;
            end else if (is_app_cmd || is_lock_cmd) begin
                tx_sh_q   <= {2'b00, cmd_idx, 6'h00, card_locked_q, lock_fail_q, 18'h00000, is_app_cmd, 5'h00,
                              card_ocr_pkg::CRC_ONES, 1'b1};
                use_crc_q <= 1'b1;
            end else if (state_q == card_ocr_pkg::ST_SEND) begin
                if (bit_cnt_q == card_ocr_pkg::FRAME_END) begin
                    cmd_out_q  <= 1'b1;
                    cmd_oe_n_q <= 1'b1;
                end else if (use_crc_q && (bit_cnt_q == card_ocr_pkg::CRC_FIRST)) begin
                    cmd_out_q  <= tx_crc[6];
                    cmd_oe_n_q <= 1'b0;
                    tx_sh_q    <= {tx_crc[5:0], 1'b1, 41'h00000000000};
                end else begin
                    cmd_out_q  <= tx_sh_q[47];
                    cmd_oe_n_q <= 1'b0;
                    tx_sh_q    <= {tx_sh_q[46:0], 1'b0};
                end
            end
        end
    end

    // Application prefix lasts exactly one following command
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            app_q <= 1'b0;
        end else if (frame_ok) begin
            app_q <= is_app_cmd && !is_idle_cmd;
        end
    end

    // Power-up status is sticky once the back end reports ready
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            power_up_status_q <= 1'b0;
        end else if (power_up_done) begin
            power_up_status_q <= 1'b1;
        end
    end

    // Password lock; no data-line block, password rides in the argument
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            card_locked_q <= 1'b0;
            lock_fail_q   <= 1'b0;
            has_pwd_q     <= 1'b0;
            pwd_q         <= '0;
        end else if (is_lock_cmd) begin
            lock_fail_q <= 1'b0;
            if (cmd_arg[card_ocr_pkg::LK_SET_PWD_BIT]) begin
                if (!has_pwd_q || pwd_match) begin
                    has_pwd_q <= 1'b1;
                    pwd_q     <= cmd_arg[card_ocr_pkg::LK_PWD_LSB +: card_ocr_pkg::PWD_W];
                end else begin
                    lock_fail_q <= 1'b1;
                end
            end else if (cmd_arg[card_ocr_pkg::LK_CLR_PWD_BIT]) begin
                if (pwd_match) begin
                    has_pwd_q     <= 1'b0;
                    card_locked_q <= 1'b0;
                end else begin
                    lock_fail_q <= 1'b1;
                end
            end else if (cmd_arg[card_ocr_pkg::LK_LOCK_BIT]) begin
                if (has_pwd_q) begin
                    card_locked_q <= 1'b1;
                end else begin
                    lock_fail_q <= 1'b1;
                end
            end else if (pwd_match) begin
                card_locked_q <= 1'b0;
            end else begin
                lock_fail_q <= 1'b1;
            end
        end
    end

    // Read watchdog; done in the limit cycle still counts as success
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_active_q  <= 1'b0;
            rd_cnt_q     <= '0;
            read_abort_q <= 1'b0;
        end else begin
            read_abort_q <= 1'b0;
            if (read_start) begin
                rd_active_q <= 1'b1;
                rd_cnt_q    <= '0;
            end else if (rd_active_q) begin
                if (read_done) begin
                    rd_active_q <= 1'b0;
                end else if (rd_cnt_q == card_ocr_pkg::TIMER_W'(READ_TIMEOUT_CYC - 1)) begin
                    rd_active_q  <= 1'b0;
                    read_abort_q <= 1'b1;
                end else begin
                    rd_cnt_q <= rd_cnt_q + 1'b1;
                end
            end
        end
    end

    // Write limit follows ext_capacity at every cycle of the wait
    assign wr_limit = ext_capacity ? card_ocr_pkg::TIMER_W'(WRITE_EXT_CYC - 1) :
                                     card_ocr_pkg::TIMER_W'(WRITE_STD_CYC - 1);

    // Write watchdog
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_active_q   <= 1'b0;
            wr_cnt_q      <= '0;
            write_abort_q <= 1'b0;
        end else begin
            write_abort_q <= 1'b0;
            if (write_start) begin
                wr_active_q <= 1'b1;
                wr_cnt_q    <= '0;
            end else if (wr_active_q) begin
                if (write_done) begin
                    wr_active_q <= 1'b0;
                end else if (wr_cnt_q >= wr_limit) begin
                    wr_active_q   <= 1'b0;
                    write_abort_q <= 1'b1;
                end else begin
                    wr_cnt_q <= wr_cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

// *** test/card_ocr_properties.sv ***
/*
 * Checker for the block: reply line, power-up flag, timeouts.
 * Assumes it is bound to the top module.
 */
`timescale 1ns/10ps
module card_ocr_properties #(
    parameter int READ_TIMEOUT_CYC = 20,
    parameter int WRITE_STD_CYC    = 40,
    parameter int WRITE_EXT_CYC    = 60
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Card bus pins
    input wire logic sd_clk,
    input wire logic cmd_in,
    input wire logic cmd_out_q,
    input wire logic cmd_oe_n_q,
    // Back end
    input wire logic power_up_done,
    input wire logic high_capacity,
    input wire logic ext_capacity,
    input wire logic read_start,
    input wire logic read_done,
    input wire logic write_start,
    input wire logic write_done,
    // Status outputs
    input wire logic read_abort_q,
    input wire logic write_abort_q,
    input wire logic card_locked_q,
    input wire logic power_up_status_q
);
    logic       seen_done_q;
    logic       sd_prev_q;
    logic       rd_act_q;
    logic       wr_act_q;
    logic [3:0] since_q;
    int         rd_cnt_q;
    int         wr_cnt_q;
    int         wr_lim;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    assign wr_lim = ext_capacity ? WRITE_EXT_CYC : WRITE_STD_CYC;

    // Power-up seen, and cycles since a sampled bus clock rise (saturates)
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seen_done_q <= 1'h0;
            sd_prev_q   <= 1'h0;
            since_q     <= 4'hf;
        end else begin
            seen_done_q <= seen_done_q | power_up_done;
            sd_prev_q   <= sd_clk;
            since_q     <= (sd_clk && !sd_prev_q) ? 4'h0 : ((since_q == 4'hf) ? 4'hf : since_q + 4'h1);
        end
    end

    // Timer references: 0 at the start edge, abort seen once the count hits the limit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_act_q <= 1'h0;
            wr_act_q <= 1'h0;
            rd_cnt_q <= 0;
            wr_cnt_q <= 0;
        end else begin
            rd_act_q <= read_start || (rd_act_q && !read_done && rd_cnt_q < READ_TIMEOUT_CYC);
            wr_act_q <= write_start || (wr_act_q && !write_done && wr_cnt_q < wr_lim);
            rd_cnt_q <= read_start ? 0 : rd_cnt_q + int'(rd_act_q);
            wr_cnt_q <= write_start ? 0 : wr_cnt_q + int'(wr_act_q);
        end
    end

    property p_busy_before_done;
        power_up_status_q |-> seen_done_q;
    endproperty
    a_busy_before_done: assert property (p_busy_before_done) else $error("ready flag before power-up");

    property p_busy_after_done;
        $rose(seen_done_q) |-> ##[0:3] power_up_status_q;
    endproperty
    a_busy_after_done: assert property (p_busy_after_done) else $error("ready flag late");

    property p_read_abort_due;
        rd_act_q && rd_cnt_q == READ_TIMEOUT_CYC |-> read_abort_q;
    endproperty
    a_read_abort_due: assert property (p_read_abort_due) else $error("read abort missing");

    property p_read_abort_cause;
        read_abort_q |-> rd_act_q && rd_cnt_q == READ_TIMEOUT_CYC;
    endproperty
    a_read_abort_cause: assert property (p_read_abort_cause) else $error("read abort unexpected");

    property p_write_abort_exact;
        write_abort_q == (wr_act_q && wr_cnt_q == wr_lim);
    endproperty
    a_write_abort_exact: assert property (p_write_abort_exact) else $error("write abort wrong cycle");

    property p_abort_single;
        read_abort_q || write_abort_q |=> !read_abort_q && !write_abort_q;
    endproperty
    a_abort_single: assert property (p_abort_single) else $error("abort longer than a cycle");

    property p_idle_high;
        cmd_oe_n_q |-> cmd_out_q;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle drive value low");

    property p_reply_start;
        $fell(cmd_oe_n_q) |-> (!cmd_oe_n_q && !cmd_out_q) [*8];
    endproperty
    a_reply_start: assert property (p_reply_start) else $error("reply start bit wrong");

    property p_line_on_clock;
        $changed(cmd_out_q) || $changed(cmd_oe_n_q) || $changed(card_locked_q) |-> since_q <= 4'h8;
    endproperty
    a_line_on_clock: assert property (p_line_on_clock) else $error("line moved off bus clock");
endmodule

bind card_operating_conditions card_ocr_properties #(
    .READ_TIMEOUT_CYC(READ_TIMEOUT_CYC), .WRITE_STD_CYC(WRITE_STD_CYC), .WRITE_EXT_CYC(WRITE_EXT_CYC)
) card_ocr_properties_i (.*);

// *** test/sd_host_model.sv ***
/*
 * Host controller model: sends command frames, collects 48-bit replies.
 * Assumes a pull-up on the command line and replies within 52 bus clocks.
 */
`timescale 1ns/10ps
module sd_host_model (
    // Card bus pins
    output logic      sd_clk,
    output logic      cmd_in,
    input  wire logic cmd_out_q,
    input  wire logic cmd_oe_n_q
);
    logic host_en;
    logic host_val;

    // Card when enabled, else host, else the pull-up
    assign cmd_in = !cmd_oe_n_q ? cmd_out_q : (host_en ? host_val : 1'h1);

    initial begin
        sd_clk   = 1'h0;
        host_en  = 1'h0;
        host_val = 1'h1;
    end

    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            c = (d[i] ^ c[6]) ? ({c[5:0], 1'h0} ^ card_ocr_pkg::CRC7_POLY) : {c[5:0], 1'h0};
        end
        return c;
    endfunction

    // One bus clock at 6.25 MHz; the clock stands low between frames
    task automatic tick(output logic seen);
        #80;
        seen = cmd_in;
        sd_clk = 1'h1;
        #80;
        sd_clk = 1'h0;
    endtask

    // Frame out, then 52 clocks of listening; all ones means silence
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad, output logic [47:0] resp);
        logic [47:0] f;
        logic        s;
        f = {2'h1, idx, arg, crc7({2'h1, idx, arg}) ^ {6'h00, bad}, 1'h1};
        resp = '1;
        #1.3; // Keeps bus edges off the system clock edges
        host_en = 1'h1;
        for (int i = 47; i >= 0; i--) begin
            host_val = f[i];
            tick(s);
        end
        host_en = 1'h0;
        for (int r = 1; r <= 52; r++) begin
            tick(s);
            if (r >= 4 && r <= 51) resp[51 - r] = s;
        end
    endtask

    // Prefixed init query repeated until ready; gives up on silence
    task automatic init_poll(input int tries, output logic [47:0] r55, output logic [47:0] r41);
        for (int n = 0; n < tries; n++) begin
            xfer(card_ocr_pkg::CMD_APP, 32'h00000000, 1'h0, r55);
            xfer(card_ocr_pkg::CMD_OP_COND, 32'h00ff8000, 1'h0, r41);
            if (r41[39] === 1'h1 || r41 === '1) break;
        end
    endtask
endmodule

// *** test/card_operating_conditions_test.sv ***
/*
 * Bench for the operating-conditions block: init queries, framing, locking, timeouts.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/10ps
module card_operating_conditions_test;
    localparam int RD_N = 20;
    localparam int WS_N = 40;
    localparam int WE_N = 60;

    logic        clk_sys, sys_rst, sd_clk, cmd_in, cmd_out_q, cmd_oe_n_q, power_up_done, high_capacity;
    logic        ext_capacity, read_start, read_done, write_start, write_done, read_abort_q, write_abort_q;
    logic        card_locked_q, power_up_status_q, wr;
    logic [47:0] r55, r41, r;
    logic [23:0] pwd;
    int          mismatches, num_checks;

    card_operating_conditions #(.READ_TIMEOUT_CYC(RD_N), .WRITE_STD_CYC(WS_N), .WRITE_EXT_CYC(WE_N))
    card_operating_conditions_i (.*);
    sd_host_model sd_host_model_i (.sd_clk, .cmd_in, .cmd_out_q, .cmd_oe_n_q);

    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Expected long reply for a power-up state and capacity class
    function automatic logic [47:0] exp_r3(input logic pu, input logic hc);
        return {2'h0, 6'h3f, pu, pu & hc, 6'h00, 9'h1ff, 15'h0000, 7'h7f, 1'h1};
    endfunction

    task automatic check_r1(input logic [47:0] rr, input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
        check("r1 head", rr[47:40], {2'h0, idx});
        check("r1 crc", rr[7:0], {sd_host_model_i.crc7(rr[47:8]), 1'h1});
        check("r1 status", rr[39:8] & m, e);
    endtask

    // Lock command; status shows the state before the command acts
    task automatic lock_step(input logic [31:0] arg, input logic [1:0] st, input logic lk);
        sd_host_model_i.xfer(card_ocr_pkg::CMD_LOCK, arg, 1'h0, r);
        check_r1(r, card_ocr_pkg::CMD_LOCK, 32'h03000000, {6'h00, st, 24'h000000});
        check("locked", card_locked_q, lk);
    endtask

    // Start a transfer, finish it at cycle d (0 is never), note the abort cycle
    task automatic run_timer(input logic w, input int d);
        int n;
        int at;
        at = 0;
        @(posedge clk_sys);
        n = w ? (ext_capacity ? WE_N : WS_N) : RD_N;
        read_start <= !w;
        write_start <= w;
        for (int c = 1; c <= n + 3; c++) begin
            @(posedge clk_sys);
            read_start <= 1'h0;
            write_start <= 1'h0;
            read_done <= !w && c == d;
            write_done <= w && c == d;
            #1;
            if ((w ? write_abort_q : read_abort_q) === 1'h1 && at == 0) at = c;
        end
        check("abort cycle", 48'(at), 48'((d > 0 && d <= n) ? 0 : n + 1));
    endtask

    initial begin
        void'($urandom(60));
        {sys_rst, high_capacity} = 2'h3;
        {power_up_done, ext_capacity, read_start, read_done, write_start, write_done} = 6'h00;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (4) @(posedge clk_sys);
        check("busy", power_up_status_q, 48'h0);
        sd_host_model_i.init_poll(1, r55, r41);
        check_r1(r55, card_ocr_pkg::CMD_APP, 32'h00000020, 32'h00000020);
        check("word early", r41, exp_r3(1'h0, 1'h1));
        // Unprefixed query and a corrupted frame both meet silence
        sd_host_model_i.xfer(card_ocr_pkg::CMD_OP_COND, $urandom, 1'h0, r);
        check("no prefix", r, '1);
        sd_host_model_i.xfer(card_ocr_pkg::CMD_APP, 32'h00000000, 1'h1, r);
        check("bad crc", r, '1);
        @(posedge clk_sys);
        power_up_done <= 1'h1;
        @(posedge clk_sys);
        power_up_done <= 1'h0;
        for (int hc = 0; hc < 2; hc++) begin
            @(posedge clk_sys);
            high_capacity <= hc[0];
            sd_host_model_i.init_poll(3, r55, r41);
            check("word ready", r41, exp_r3(1'h1, hc[0]));
        end
        check("ready", power_up_status_q, 48'h1);
        pwd = $urandom;
        lock_step({pwd, 8'h01}, 2'h0, 1'h0);
        lock_step({pwd, 8'h04}, 2'h0, 1'h1);
        lock_step({~pwd, 8'h00}, 2'h2, 1'h1);
        lock_step({pwd, 8'h00}, 2'h3, 1'h0);
        sd_host_model_i.xfer(card_ocr_pkg::CMD_APP, 32'h00000000, 1'h0, r);
        check_r1(r, card_ocr_pkg::CMD_APP, 32'h02000000, 32'h00000000);
        // Timeout corners, then random transfers
        run_timer(1'h0, 0);
        run_timer(1'h0, RD_N - 1);
        run_timer(1'h0, RD_N);
        run_timer(1'h1, WS_N - 1);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            ext_capacity <= 1'($urandom_range(0, 1));
            wr = 1'($urandom_range(0, 1));
            run_timer(wr, (i < 2) ? 0 : int'($urandom_range(0, 61)));
        end
        tally_and_finish();
    end

    // Thirteen frames of about 16 us each plus timers fit well inside this
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
endmodule
